// ---- core/fspg_guard.sv ----
// Flash self-program guard: access checks, stall and busy tracking
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/10ps

module fspg_guard #(
  parameter logic [15:0] LDR_START_RST  = 16'hF000,
  parameter logic [15:0] STALL_START    = 16'hE000
) (
  input  wire logic               clk_sys,
  input  wire logic               srst,
  input  wire logic [3:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  input  wire logic [15:0]        fetch_addr,
  input  wire fspg_pkg::fspg_store_s store_req,
  input  wire fspg_pkg::fspg_tread_s tread_req,
  input  wire logic               flash_done,
  output logic                    flash_start_ff,
  output logic                    flash_erase_ff,
  output logic [15:0]             flash_page_ff,
  output logic                    cpu_halt_ff,
  output logic                    conc_block_ff,
  output logic                    tread_ok_ff,
  output logic                    tread_deny_ff,
  output logic                    irq_suppress_ff
);

  logic [5:0]              lock_ff;
  logic [15:0]             ldr_start_ff;
  logic                    vec_ldr_ff;
  logic                    busy_ff;
  logic                    denied_ff;
  logic                    ack_ff;
  fspg_pkg::fspg_state_e   state_ff;

  function automatic logic in_ldr(input logic [15:0] a, input logic [15:0] ls);
    return a >= ls;
  endfunction

  // Loader start is clamped into the stalling region
  logic [15:0] ldr_start;
  assign ldr_start = (ldr_start_ff < STALL_START) ? STALL_START : ldr_start_ff;

  logic [1:0] app_lk;
  logic [1:0] ldr_lk;
  logic       fetch_in_ldr;
  logic       tgt_in_ldr;
  logic       tgt_stall;
  logic       wr_locked;
  logic       store_ok;
  localparam int LCK_APP_LO_W = fspg_pkg::LCK_APP_LO;
  localparam int LCK_LDR_LO_W = fspg_pkg::LCK_LDR_LO;
  assign app_lk       = lock_ff[LCK_APP_LO_W+:2];
  assign ldr_lk       = lock_ff[LCK_LDR_LO_W+:2];
  assign fetch_in_ldr = in_ldr(fetch_addr, ldr_start);
  assign tgt_in_ldr   = in_ldr(store_req.page_addr, ldr_start);
  assign tgt_stall    = store_req.page_addr >= STALL_START;
  // Mode bits 4/5 take no part in the check
  assign wr_locked    = tgt_in_ldr ? ~ldr_lk[0] : ~app_lk[0];
  assign store_ok     = store_req.valid && fetch_in_ldr && !wr_locked
                        && state_ff == fspg_pkg::FSPG_IDLE;

  // Avalon slave: one wait cycle, answer on second cycle
  logic req;
  assign req = (avs_read | avs_write) & ~ack_ff;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end
  assign avs_waitrequest = ~ack_ff;

  logic wr_hit;
  assign wr_hit = avs_write & ack_ff;

  // Lock fields: writes only clear bits; erase-all restores
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lock_ff <= 6'h3F;
    end else if (wr_hit && avs_address == fspg_pkg::OFF_CTRL
                 && avs_writedata[fspg_pkg::CTL_ERASE_ALL]) begin
      lock_ff <= 6'h3F;
    end else if (wr_hit && avs_address == fspg_pkg::OFF_LOCK) begin
      lock_ff <= lock_ff & avs_writedata[5:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ldr_start_ff <= LDR_START_RST;
      vec_ldr_ff   <= 1'b0;
    end else if (wr_hit && avs_address == fspg_pkg::OFF_SIZE) begin
      ldr_start_ff <= avs_writedata[15:0];
    end else if (wr_hit && avs_address == fspg_pkg::OFF_CTRL) begin
      vec_ldr_ff <= avs_writedata[fspg_pkg::CTL_VEC_LDR];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else begin
      unique case (avs_address)
        fspg_pkg::OFF_LOCK:   avs_readdata <= {26'h0, lock_ff};
        fspg_pkg::OFF_CTRL:   avs_readdata <= {28'h0, vec_ldr_ff, 3'b000};
        fspg_pkg::OFF_STATUS: avs_readdata <= {28'h0, denied_ff,
                                               state_ff != fspg_pkg::FSPG_IDLE,
                                               cpu_halt_ff, busy_ff};
        fspg_pkg::OFF_SIZE:   avs_readdata <= {16'h0, ldr_start};
        default:              avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Operation sequencer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_ff       <= fspg_pkg::FSPG_IDLE;
      flash_start_ff <= 1'b0;
      flash_erase_ff <= 1'b0;
      flash_page_ff  <= 16'h0000;
      denied_ff      <= 1'b0;
    end else begin
      flash_start_ff <= 1'b0;
      if (store_req.valid && !store_ok) begin
        denied_ff <= 1'b1;
      end else if (wr_hit && avs_address == fspg_pkg::OFF_STATUS) begin
        denied_ff <= 1'b0;
      end
      unique case (state_ff)
        fspg_pkg::FSPG_IDLE: begin
          if (store_ok) begin
            flash_start_ff <= 1'b1;
            flash_erase_ff <= store_req.erase;
            flash_page_ff  <= store_req.page_addr;
            state_ff <= tgt_stall ? fspg_pkg::FSPG_STALL : fspg_pkg::FSPG_CONC;
          end
        end
        fspg_pkg::FSPG_CONC: if (flash_done) state_ff <= fspg_pkg::FSPG_IDLE;
        fspg_pkg::FSPG_STALL: if (flash_done) state_ff <= fspg_pkg::FSPG_IDLE;
        default: state_ff <= fspg_pkg::FSPG_IDLE;
      endcase
    end
  end

  // Halt follows the stalling state, released on done
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cpu_halt_ff <= 1'b0;
    end else if (store_ok && tgt_stall) begin
      cpu_halt_ff <= 1'b1;
    end else if (flash_done) begin
      cpu_halt_ff <= 1'b0;
    end
  end

  // Busy flag: set wins over clear; re-enable ignored while operating
  logic clr_busy;
  assign clr_busy = wr_hit && avs_address == fspg_pkg::OFF_CTRL
                    && (avs_writedata[fspg_pkg::CTL_PAGE_LOAD]
                        || (avs_writedata[fspg_pkg::CTL_REENABLE]
                            && state_ff == fspg_pkg::FSPG_IDLE));
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busy_ff <= 1'b0;
    end else if (store_ok && !tgt_stall) begin
      busy_ff <= 1'b1;
    end else if (clr_busy) begin
      busy_ff <= 1'b0;
    end
  end

  // Concurrent region blocked while any operation runs or busy stands
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      conc_block_ff <= 1'b0;
    end else begin
      conc_block_ff <= busy_ff || (state_ff != fspg_pkg::FSPG_IDLE)
                       || store_ok;
    end
  end

  // Table read checks, registered one cycle
  logic t_ldr;
  logic t_deny;
  assign t_ldr  = in_ldr(tread_req.addr, ldr_start);
  assign t_deny = (t_ldr && !fetch_in_ldr && !ldr_lk[1])
                  || (!t_ldr && fetch_in_ldr && !app_lk[1])
                  || (tread_req.addr < STALL_START && conc_block_ff);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tread_ok_ff   <= 1'b0;
      tread_deny_ff <= 1'b0;
    end else begin
      tread_ok_ff   <= tread_req.valid && !t_deny;
      tread_deny_ff <= tread_req.valid && t_deny;
    end
  end

  // Interrupt suppression by lock fields and vector placement
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_suppress_ff <= 1'b0;
    end else begin
      irq_suppress_ff <= (vec_ldr_ff && !fetch_in_ldr && !app_lk[1])
                         || (!vec_ldr_ff && fetch_in_ldr && !ldr_lk[1]);
    end
  end

  a_store_from_app: assert property (@(posedge clk_sys) disable iff (srst)
    store_req.valid && !fetch_in_ldr |=> !flash_start_ff)
    else $error("store from application started an operation");
  a_stall_halts: assert property (@(posedge clk_sys) disable iff (srst)
    store_ok && tgt_stall |=> cpu_halt_ff throughout (!flash_done)[*1])
    else $error("stalling operation did not halt core");
  a_conc_no_halt: assert property (@(posedge clk_sys) disable iff (srst)
    state_ff == fspg_pkg::FSPG_CONC |-> !cpu_halt_ff)
    else $error("concurrent operation halted core");
  a_halt_release: assert property (@(posedge clk_sys) disable iff (srst)
    cpu_halt_ff && flash_done |=> !cpu_halt_ff)
    else $error("halt not released on done");
  a_busy_set: assert property (@(posedge clk_sys) disable iff (srst)
    store_ok && !tgt_stall |=> busy_ff ##1 conc_block_ff)
    else $error("busy not set on concurrent operation");
  a_busy_read: assert property (@(posedge clk_sys) disable iff (srst)
    ack_ff && avs_read && avs_address == fspg_pkg::OFF_STATUS
    |=> avs_readdata[0] == $past(busy_ff))
    else $error("busy flag misread");
  a_app_nowrite: assert property (@(posedge clk_sys) disable iff (srst)
    store_req.valid && !tgt_in_ldr && !app_lk[0] |=> !flash_start_ff)
    else $error("locked application write started");
  a_ldr_noread: assert property (@(posedge clk_sys) disable iff (srst)
    tread_req.valid && t_ldr && !fetch_in_ldr && !ldr_lk[1] |=> tread_deny_ff)
    else $error("locked loader table read allowed");
  a_lock_sticky: assert property (@(posedge clk_sys) disable iff (srst)
    !(wr_hit && avs_address == fspg_pkg::OFF_CTRL) |=> (lock_ff & ~$past(lock_ff)) == 6'h00)
    else $error("lock bit unprogrammed without erase");

  // Store path
  a_ldr_any_page: assert property (@(posedge clk_sys) disable iff (srst)
    store_ok && tgt_in_ldr |=> flash_start_ff && flash_page_ff == $past(store_req.page_addr))
    else $error("loader page store not started");
  a_store_class: assert property (@(posedge clk_sys) disable iff (srst)
    store_ok |=> (state_ff == fspg_pkg::FSPG_STALL) == $past(tgt_stall))
    else $error("operation class does not follow target page");
  a_conc_op_runs: assert property (@(posedge clk_sys) disable iff (srst)
    store_ok && !tgt_stall |=> !cpu_halt_ff)
    else $error("concurrent operation stalled core");
  a_one_op: assert property (@(posedge clk_sys) disable iff (srst)
    state_ff != fspg_pkg::FSPG_IDLE |=> !flash_start_ff)
    else $error("second operation started while busy");
  a_start_pulse: assert property (@(posedge clk_sys) disable iff (srst)
    flash_start_ff |=> !flash_start_ff)
    else $error("start longer than one cycle");
  a_denied_set: assert property (@(posedge clk_sys) disable iff (srst)
    store_req.valid && !store_ok |=> denied_ff)
    else $error("refused store not flagged");
  a_halt_hold: assert property (@(posedge clk_sys) disable iff (srst)
    cpu_halt_ff && !flash_done |=> cpu_halt_ff)
    else $error("halt dropped before done");

  // Concurrent region blocking, busy flag, erase-all and bus answer
  a_conc_blocked: assert property (@(posedge clk_sys) disable iff (srst)
    state_ff != fspg_pkg::FSPG_IDLE |=> conc_block_ff)
    else $error("concurrent region readable during operation");
  a_conc_read_deny: assert property (@(posedge clk_sys) disable iff (srst)
    tread_req.valid && tread_req.addr < STALL_START && conc_block_ff |=> tread_deny_ff)
    else $error("blocked concurrent region read allowed");
  a_stall_readable: assert property (@(posedge clk_sys) disable iff (srst)
    state_ff == fspg_pkg::FSPG_CONC && tread_req.valid && tread_req.addr >= STALL_START
    && t_ldr == fetch_in_ldr |=> tread_ok_ff)
    else $error("stalling region unreadable during concurrent operation");
  a_ldr_in_stall: assert property (@(posedge clk_sys) disable iff (srst)
    ldr_start >= STALL_START)
    else $error("loader region outside stalling region");
  a_busy_blocks: assert property (@(posedge clk_sys) disable iff (srst)
    busy_ff |=> conc_block_ff)
    else $error("busy set but region readable");
  a_busy_clear_load: assert property (@(posedge clk_sys) disable iff (srst)
    wr_hit && avs_address == fspg_pkg::OFF_CTRL && avs_writedata[fspg_pkg::CTL_PAGE_LOAD]
    && !store_ok |=> !busy_ff)
    else $error("page load did not clear busy");
  a_busy_hold: assert property (@(posedge clk_sys) disable iff (srst)
    busy_ff && state_ff != fspg_pkg::FSPG_IDLE && !store_ok
    && !(wr_hit && avs_writedata[fspg_pkg::CTL_PAGE_LOAD]) |=> busy_ff)
    else $error("busy cleared while operating");
  a_erase_all: assert property (@(posedge clk_sys) disable iff (srst)
    wr_hit && avs_address == fspg_pkg::OFF_CTRL && avs_writedata[fspg_pkg::CTL_ERASE_ALL]
    |=> lock_ff == 6'h3F)
    else $error("erase-all did not restore locks");
  a_ack_pulse: assert property (@(posedge clk_sys) disable iff (srst)
    ack_ff |=> !ack_ff)
    else $error("bus answer longer than one cycle");

  // Lock field modes
  a_modes_ignored: assert property (@(posedge clk_sys) disable iff (srst)
    store_req.valid && fetch_in_ldr && state_ff == fspg_pkg::FSPG_IDLE
    && (tgt_in_ldr ? ldr_lk[0] : app_lk[0]) |=> flash_start_ff)
    else $error("unlocked store refused");
  a_app_free_write: assert property (@(posedge clk_sys) disable iff (srst)
    store_req.valid && fetch_in_ldr && !tgt_in_ldr && app_lk == fspg_pkg::LK_FREE
    && state_ff == fspg_pkg::FSPG_IDLE |=> flash_start_ff)
    else $error("free application write refused");
  a_free_read: assert property (@(posedge clk_sys) disable iff (srst)
    tread_req.valid && app_lk == fspg_pkg::LK_FREE && ldr_lk == fspg_pkg::LK_FREE
    && !conc_block_ff |=> tread_ok_ff)
    else $error("free table read refused");
  a_app_nowr_read: assert property (@(posedge clk_sys) disable iff (srst)
    tread_req.valid && !t_ldr && fetch_in_ldr && app_lk == fspg_pkg::LK_NOWR
    && !conc_block_ff |=> tread_ok_ff)
    else $error("application read refused under write lock");
  a_app_all_read: assert property (@(posedge clk_sys) disable iff (srst)
    tread_req.valid && !t_ldr && fetch_in_ldr && app_lk == fspg_pkg::LK_ALL
    |=> tread_deny_ff)
    else $error("locked application read allowed");
  a_app_nord_read: assert property (@(posedge clk_sys) disable iff (srst)
    tread_req.valid && !t_ldr && fetch_in_ldr && app_lk == fspg_pkg::LK_NORD
    |=> tread_deny_ff)
    else $error("read-locked application read allowed");
  a_app_nord_write: assert property (@(posedge clk_sys) disable iff (srst)
    store_req.valid && fetch_in_ldr && !tgt_in_ldr && app_lk == fspg_pkg::LK_NORD
    && state_ff == fspg_pkg::FSPG_IDLE |=> flash_start_ff)
    else $error("read-locked application write refused");
  a_ldr_nowr_write: assert property (@(posedge clk_sys) disable iff (srst)
    store_req.valid && tgt_in_ldr && ldr_lk == fspg_pkg::LK_NOWR |=> !flash_start_ff)
    else $error("write-locked loader write started");
  a_ldr_all_write: assert property (@(posedge clk_sys) disable iff (srst)
    store_req.valid && tgt_in_ldr && ldr_lk == fspg_pkg::LK_ALL |=> !flash_start_ff)
    else $error("locked loader write started");
  a_ldr_nord_read: assert property (@(posedge clk_sys) disable iff (srst)
    tread_req.valid && t_ldr && !fetch_in_ldr && ldr_lk == fspg_pkg::LK_NORD
    |=> tread_deny_ff)
    else $error("read-locked loader read allowed");
  a_ldr_nord_write: assert property (@(posedge clk_sys) disable iff (srst)
    store_req.valid && fetch_in_ldr && tgt_in_ldr && ldr_lk == fspg_pkg::LK_NORD
    && state_ff == fspg_pkg::FSPG_IDLE |=> flash_start_ff)
    else $error("read-locked loader write refused");

  // Interrupt suppression
  a_irq_app: assert property (@(posedge clk_sys) disable iff (srst)
    vec_ldr_ff && !fetch_in_ldr && !app_lk[1] |=> irq_suppress_ff)
    else $error("interrupts not suppressed in application");
  a_irq_ldr: assert property (@(posedge clk_sys) disable iff (srst)
    !vec_ldr_ff && fetch_in_ldr && !ldr_lk[1] |=> irq_suppress_ff)
    else $error("interrupts not suppressed in loader");
  a_irq_own: assert property (@(posedge clk_sys) disable iff (srst)
    vec_ldr_ff && fetch_in_ldr |=> !irq_suppress_ff)
    else $error("interrupts suppressed beside own vectors");

  c_conc_op:  cover property (@(posedge clk_sys) state_ff == fspg_pkg::FSPG_CONC ##1 flash_done);
  c_stall_op: cover property (@(posedge clk_sys) state_ff == fspg_pkg::FSPG_STALL);
  c_denied:   cover property (@(posedge clk_sys) tread_deny_ff);
  c_irq_sup:  cover property (@(posedge clk_sys) irq_suppress_ff);
  c_busy_clr: cover property (@(posedge clk_sys) busy_ff ##1 !busy_ff);

endmodule // fspg_guard

// ---- core/fspg_pkg.sv ----
// Package for the flash self-program guard: register map, fields, states
package fspg_pkg;

  // Register byte offsets (word aligned)
  localparam logic [3:0] OFF_LOCK    = 4'h0;
  localparam logic [3:0] OFF_CTRL    = 4'h4;
  localparam logic [3:0] OFF_STATUS  = 4'h8;
  localparam logic [3:0] OFF_SIZE    = 4'hC;

  // Lock register fields
  localparam int LCK_APP_LO    = 0;
  localparam int LCK_LDR_LO    = 2;
  localparam int LCK_MODE1     = 4;
  localparam int LCK_MODE2     = 5;
  localparam logic [1:0] LCK_UNPROG = 2'b11;

  // Control register fields (write one to act; CTL_VEC_LDR holds the written value)
  localparam int CTL_REENABLE  = 0;
  localparam int CTL_PAGE_LOAD = 1;
  localparam int CTL_ERASE_ALL = 2;
  localparam int CTL_VEC_LDR   = 3;

  // Status register fields
  localparam int ST_BUSY       = 0;
  localparam int ST_HALT       = 1;
  localparam int ST_ACTIVE     = 2;
  localparam int ST_DENIED     = 3;

  // Lock codes, programmed reads as 0
  localparam logic [1:0] LK_FREE  = 2'b11;
  localparam logic [1:0] LK_NOWR  = 2'b10;
  localparam logic [1:0] LK_ALL   = 2'b00;
  localparam logic [1:0] LK_NORD  = 2'b01;

  typedef enum logic [2:0] {
    FSPG_IDLE  = 3'b001,
    FSPG_CONC  = 3'b010,
    FSPG_STALL = 3'b100
  } fspg_state_e;

  // Program-store request from the core
  typedef struct packed {
    logic        valid;
    logic        erase;
    logic [15:0] page_addr;
  } fspg_store_s;

  // Table read request from the core
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } fspg_tread_s;

endpackage

// ---- tb/fspg_core_model.sv ----
// Stand-in for the core fetch path and the flash controller
`timescale 1ns/10ps
module fspg_core_model (
  input  wire logic             clk_sys,
  input  wire logic             flash_start_ff,
  output logic [15:0]           fetch_addr,
  output fspg_pkg::fspg_store_s store_req,
  output fspg_pkg::fspg_tread_s tread_req,
  output logic                  flash_done
);
  int done_delay;
  int left;
  initial begin
    done_delay = 3;
    left = 0;
    fetch_addr = 16'hF000;
    store_req = '0;
    tread_req = '0;
    flash_done = 1'b0;
  end
  // Completion only after a real start, prompt or slow
  always @(posedge clk_sys) begin
    flash_done <= 1'b0;
    if (flash_start_ff) begin
      left <= done_delay;
    end else if (left != 0) begin
      left <= left - 1;
      flash_done <= (left == 1);
    end
  end
  // Sets fetch address and a one-cycle store or table-read request; fetch holds until the next call
  task automatic req(input logic [15:0] fa, input logic [15:0] ad, input logic [1:0] k);
    @(posedge clk_sys);
    fetch_addr <= fa;
    store_req <= '{k[0], k[1], ad};
    tread_req <= '{k == 2'd2, ad};
    @(posedge clk_sys);
    store_req.valid <= 1'b0;
    tread_req.valid <= 1'b0;
  endtask
endmodule // fspg_core_model

// ---- tb/fspg_guard_bench.sv ----
// Self-checking bench for the flash self-program guard
`timescale 1ns/10ps
module fspg_guard_bench;
  typedef struct packed {
    logic [5:0]  lk;
    logic [15:0] fa;
    logic [15:0] ad;
    logic [1:0]  k;
    logic        ok;
  } fspg_row_s;
  logic                  clk_sys;
  logic                  srst;
  logic [3:0]            avs_address;
  logic                  avs_read;
  logic                  avs_write;
  logic [31:0]           avs_writedata;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  logic [15:0]           fetch_addr;
  fspg_pkg::fspg_store_s store_req;
  fspg_pkg::fspg_tread_s tread_req;
  logic                  flash_done;
  logic                  flash_start_ff;
  logic                  flash_erase_ff;
  logic [15:0]           flash_page_ff;
  logic                  cpu_halt_ff;
  logic                  conc_block_ff;
  logic                  tread_ok_ff;
  logic                  tread_deny_ff;
  logic                  irq_suppress_ff;
  logic [31:0]           q;
  int                    err_count = 0;
  int                    samples_checked = 0;
  // Lock, fetch, target, kind (1 write, 3 erase, 2 table read), allowed
  fspg_row_s rows [16] = '{
    '{6'h3F, 16'hF000, 16'h1000, 2'd1, 1'b1}, '{6'h3F, 16'h1000, 16'h1000, 2'd1, 1'b0},
    '{6'h3F, 16'hF000, 16'hF100, 2'd3, 1'b1}, '{6'h3E, 16'hF000, 16'h1000, 2'd1, 1'b0},
    '{6'h3E, 16'hF000, 16'h1000, 2'd2, 1'b1}, '{6'h3C, 16'hF000, 16'h1000, 2'd3, 1'b0},
    '{6'h3C, 16'hF000, 16'h1000, 2'd2, 1'b0}, '{6'h3D, 16'hF000, 16'h1000, 2'd1, 1'b1},
    '{6'h3D, 16'hF000, 16'h1000, 2'd2, 1'b0}, '{6'h3D, 16'h1000, 16'h1000, 2'd2, 1'b1},
    '{6'h3B, 16'hF000, 16'hF100, 2'd1, 1'b0}, '{6'h33, 16'h1000, 16'hF100, 2'd2, 1'b0},
    '{6'h33, 16'hF000, 16'hF100, 2'd1, 1'b0}, '{6'h37, 16'hF000, 16'hF100, 2'd1, 1'b1},
    '{6'h37, 16'h1000, 16'hF100, 2'd2, 1'b0}, '{6'h0F, 16'hF000, 16'h1000, 2'd1, 1'b1}};

  fspg_guard DUT (.*);
  fspg_core_model cm (.*);

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic c, input string m);
    samples_checked++;
    if (c !== 1'b1) begin
      err_count++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask

  task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk(n < 50, "bus hang");
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input string m);
    bus(a, 1'b0, 32'h0000_0000);
    chk(q === e, m);
  endtask

  task automatic go(input logic [15:0] fa, input logic [15:0] ad, input logic [1:0] k);
    cm.req(fa, ad, k);
    #1;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (flash_done !== 1'b1 && n < 60) begin
      @(posedge clk_sys);
      n++;
    end
    chk(n < 60, "done timeout");
    @(posedge clk_sys);
    #1;
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    wrap_up();
  end

  initial begin
    srst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    foreach (rows[i]) begin
      bus(4'h4, 1'b1, 32'h0000_0005);
      bus(4'h0, 1'b1, {26'h0, rows[i].lk});
      go(rows[i].fa, rows[i].ad, rows[i].k);
      if (rows[i].k[0]) begin
        chk(flash_start_ff === rows[i].ok, "start");
        if (rows[i].ok) begin
          chk(flash_page_ff === rows[i].ad && flash_erase_ff === rows[i].k[1], "page");
          chk(cpu_halt_ff === (rows[i].ad >= 16'hE000), "halt");
          chk(conc_block_ff === 1'b1, "block");
          wait_done();
        end
      end else begin
        chk(tread_ok_ff === rows[i].ok && tread_deny_ff === !rows[i].ok, "tread");
      end
    end
    // Concurrent-region update, slow completion
    cm.done_delay = 20;
    bus(4'h8, 1'b1, 32'h0000_0000);
    go(16'hF000, 16'h2000, 2'd1);
    rdc(4'h8, 32'h0000_0005, "busy");
    go(16'hF000, 16'h2000, 2'd2);
    chk(tread_deny_ff === 1'b1, "conc read");
    go(16'hF000, 16'hF100, 2'd2);
    chk(tread_ok_ff === 1'b1, "stall read");
    go(16'hF000, 16'h3000, 2'd1);
    chk(flash_start_ff === 1'b0, "second op");
    wait_done();
    rdc(4'h8, 32'h0000_0009, "busy held");
    bus(4'h4, 1'b1, 32'h0000_0002);
    rdc(4'h8, 32'h0000_0008, "busy cleared");
    // Stalling-region boundary page
    cm.done_delay = 8;
    go(16'hF000, 16'hE000, 2'd3);
    repeat (6) begin
      @(posedge clk_sys);
      #1;
      chk(cpu_halt_ff === 1'b1, "halt held");
    end
    wait_done();
    chk(cpu_halt_ff === 1'b0, "halt released");
    bus(4'h4, 1'b1, 32'h0000_000C);
    bus(4'h0, 1'b1, 32'h0000_003C);
    go(16'h1000, 16'h0000, 2'd0);
    chk(irq_suppress_ff === 1'b1, "irq app");
    go(16'hF000, 16'h0000, 2'd0);
    chk(irq_suppress_ff === 1'b0, "irq ldr");
    bus(4'h4, 1'b1, 32'h0000_0004);
    bus(4'h0, 1'b1, 32'h0000_0037);
    @(posedge clk_sys);
    #1;
    chk(irq_suppress_ff === 1'b1, "irq ldr2");
    bus(4'h0, 1'b1, 32'h0000_0030);
    bus(4'h0, 1'b1, 32'h0000_003F);
    rdc(4'h0, 32'h0000_0030, "lock sticky");
    bus(4'hC, 1'b1, 32'h0000_1000);
    rdc(4'hC, 32'h0000_E000, "loader clamp");
    // Second reset in mid-run
    srst <= 1'b1;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    rdc(4'h0, 32'h0000_003F, "lock reset");
    rdc(4'hC, 32'h0000_F000, "loader start");
    rdc(4'h8, 32'h0000_0000, "status reset");
    rdc(4'h2, 32'h0000_0000, "unmapped");
    wrap_up();
  end
endmodule // fspg_guard_bench
